// ==== design/fwpc_ctrl.sv ====
/*
 * Host-side controller for a parallel boot-block flash: runs command
 * sequences on the flash pins, polls status, and owns the power-down/reset
 * and write-protect pins.
 * Assumes pin inputs synchronous to clk and an external tri-state for dq.
 */
`timescale 1ns/1ps
`include "fwpc_params.svh"

module fwpc_ctrl #(
	parameter int TW          = 8,
	parameter int ACC_CYC     = (`FWPC_T_ACC_NS + `FWPC_CLK_NS - 1) / `FWPC_CLK_NS,
	parameter int WE_CYC      = (`FWPC_T_WE_LOW_NS + `FWPC_CLK_NS - 1) / `FWPC_CLK_NS,
	parameter int RP_LOW_CYC  = (`FWPC_T_RP_LOW_NS + `FWPC_CLK_NS - 1) / `FWPC_CLK_NS,
	parameter int RECOVER_CYC = (`FWPC_T_PD_RECOVER_NS + `FWPC_CLK_NS - 1) / `FWPC_CLK_NS
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// system supply and protection
	input  wire logic                    supply_good,
	input  wire logic                    wp_unlock,
	input  wire logic                    abort,
	// user requests
	input  wire logic                    req_valid,
	input  wire fwpc_pkg::fwpc_req_t     req,
	output logic                         req_ready,
	output logic                         done,
	output fwpc_pkg::fwpc_rsp_t          rsp,
	// flash pins
	output fwpc_pkg::fwpc_pins_t         pins,
	input  wire logic [`FWPC_DATA_W-1:0] dq_in
);

	fwpc_pkg::fwpc_state_t state_reg, state_next;
	fwpc_pkg::fwpc_op_t    op_reg, op_next;
	fwpc_pkg::fwpc_act_t   act;
	fwpc_pkg::fwpc_pins_t  pins_reg, pins_next;
	fwpc_pkg::fwpc_rsp_t   rsp_reg, rsp_next;
	logic [`FWPC_ADDR_W-1:0] addr_reg, addr_next;
	logic [`FWPC_DATA_W-1:0] wdata_reg, wdata_next;
	logic [`FWPC_DATA_W-1:0] bus_reg, bus_next;
	logic [`FWPC_DATA_W-1:0] pdata;
	logic [7:0]              status_reg, status_next;
	logic [2:0]              step_reg, step_next;
	logic                    pcmd;
	logic                    array_reg, array_next;
	logic                    sleep_reg, sleep_next;
	logic                    abort_reg, abort_next;
	logic                    ready_reg, ready_next;
	logic                    done_reg, done_next;
	logic                    tmr_load;
	logic [TW-1:0]           tmr_val;
	logic                    tmr_expired;

	fwpc_timer #(.W(TW)) u_timer (
		.clk      (clk),
		.reset_n  (reset_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_expired)
	);

	// bus action for the current step of the current operation
	always_comb begin
		act   = fwpc_pkg::ACT_FINISH;
		pdata = '0;
		pcmd  = 1'b0;
		case (op_reg)
			fwpc_pkg::OP_PROGRAM, fwpc_pkg::OP_ERASE: begin
				case (step_reg)
					3'h0: begin
						act   = fwpc_pkg::ACT_WRITE;
						pcmd  = 1'b1;
						pdata = {8'h00, (op_reg == fwpc_pkg::OP_PROGRAM) ?
							`FWPC_CMD_PROGRAM : `FWPC_CMD_ERASE};
					end
					3'h1: begin
						// second cycle of the pair commits the change
						act   = fwpc_pkg::ACT_WRITE;
						pcmd  = (op_reg == fwpc_pkg::OP_ERASE);
						pdata = (op_reg == fwpc_pkg::OP_PROGRAM) ? wdata_reg :
							{8'h00, `FWPC_CMD_CONFIRM};
					end
					3'h2: begin
						act = fwpc_pkg::ACT_READ;
					end
					3'h3: begin
						act   = fwpc_pkg::ACT_WRITE;
						pcmd  = 1'b1;
						pdata = {8'h00, `FWPC_CMD_READ_ARRAY};
					end
					default: act = fwpc_pkg::ACT_FINISH;
				endcase
			end
			fwpc_pkg::OP_READ, fwpc_pkg::OP_READ_STATUS: begin
				case (step_reg)
					3'h0: begin
						act   = fwpc_pkg::ACT_WRITE;
						pcmd  = 1'b1;
						pdata = {8'h00, (op_reg == fwpc_pkg::OP_READ) ?
							`FWPC_CMD_READ_ARRAY : `FWPC_CMD_READ_STAT};
					end
					3'h1: act = fwpc_pkg::ACT_READ;
					default: act = fwpc_pkg::ACT_FINISH;
				endcase
			end
			fwpc_pkg::OP_CLR_STATUS: begin
				if (step_reg == 3'h0) begin
					act   = fwpc_pkg::ACT_WRITE;
					pcmd  = 1'b1;
					pdata = {8'h00, `FWPC_CMD_CLR_STAT};
				end
			end
			default: act = fwpc_pkg::ACT_FINISH;
		endcase
	end

	always_comb begin
		state_next  = state_reg;
		op_next     = op_reg;
		addr_next   = addr_reg;
		wdata_next  = wdata_reg;
		bus_next    = bus_reg;
		status_next = status_reg;
		step_next   = step_reg;
		array_next  = array_reg;
		sleep_next  = sleep_reg;
		abort_next  = 1'b0;
		rsp_next    = rsp_reg;
		done_next   = 1'b0;
		tmr_load    = 1'b0;
		tmr_val     = '0;
		case (state_reg)
			fwpc_pkg::S_PDOWN: begin
				// flash holds no status through power-down
				status_next = '0;
				if (sleep_reg && req_valid && ready_reg && req.op == fwpc_pkg::OP_WAKE) begin
					sleep_next = 1'b0;
					op_next    = fwpc_pkg::OP_WAKE;
				end
				if (tmr_expired && supply_good && !sleep_reg) begin
					state_next = fwpc_pkg::S_RECOVER;
					tmr_load   = 1'b1;
					tmr_val    = TW'(RECOVER_CYC);
				end
			end
			fwpc_pkg::S_RECOVER: begin
				if (tmr_expired) begin
					state_next = fwpc_pkg::S_IDLE;
					array_next = 1'b1;
					if (op_reg == fwpc_pkg::OP_WAKE || abort_reg) begin
						// a later power cut must not answer this wake again
						op_next          = fwpc_pkg::OP_READ;
						done_next        = 1'b1;
						rsp_next         = '0;
						rsp_next.aborted = abort_reg;
						rsp_next.fail    = abort_reg;
					end
				end else begin
					abort_next = abort_reg;
				end
			end
			fwpc_pkg::S_IDLE: begin
				if (req_valid && ready_reg) begin
					op_next    = req.op;
					addr_next  = req.addr;
					wdata_next = req.wdata;
					// skip the read-array write when already in array mode
					step_next  = (req.op == fwpc_pkg::OP_READ && array_reg) ? 3'h1 : 3'h0;
					if (req.op == fwpc_pkg::OP_SLEEP) begin
						state_next = fwpc_pkg::S_PDOWN;
						sleep_next = 1'b1;
						done_next  = 1'b1;
						rsp_next   = '0;
						tmr_load   = 1'b1;
						tmr_val    = TW'(RP_LOW_CYC);
					end else if (req.op == fwpc_pkg::OP_WAKE) begin
						done_next = 1'b1;
						rsp_next  = '0;
					end else begin
						state_next = fwpc_pkg::S_PLAN;
					end
				end
			end
			fwpc_pkg::S_PLAN: begin
				case (act)
					fwpc_pkg::ACT_WRITE: begin
						state_next = fwpc_pkg::S_WSET;
						bus_next   = pdata;
						if (pcmd)
							array_next = (pdata[7:0] == `FWPC_CMD_READ_ARRAY);
					end
					fwpc_pkg::ACT_READ: begin
						state_next = fwpc_pkg::S_RACC;
						tmr_load   = 1'b1;
						tmr_val    = TW'(ACC_CYC);
					end
					default: begin
						state_next          = fwpc_pkg::S_IDLE;
						done_next           = 1'b1;
						rsp_next.rdata      = bus_reg;
						rsp_next.status     = status_reg;
						rsp_next.aborted    = 1'b0;
						rsp_next.lock_err   = status_reg[`FWPC_SR_LOCK];
						rsp_next.supply_err = status_reg[`FWPC_SR_SUPPLY];
						rsp_next.fail       = (op_reg == fwpc_pkg::OP_PROGRAM ||
							op_reg == fwpc_pkg::OP_ERASE) &&
							(status_reg[`FWPC_SR_LOCK] || status_reg[`FWPC_SR_SUPPLY] ||
							status_reg[`FWPC_SR_PROG_ERR] || status_reg[`FWPC_SR_ERASE_ERR]);
					end
				endcase
			end
			fwpc_pkg::S_WSET: begin
				state_next = fwpc_pkg::S_WPULSE;
				tmr_load   = 1'b1;
				tmr_val    = TW'(WE_CYC);
			end
			fwpc_pkg::S_WPULSE: begin
				if (tmr_expired)
					state_next = fwpc_pkg::S_WHOLD;
			end
			fwpc_pkg::S_WHOLD: begin
				state_next = fwpc_pkg::S_PLAN;
				step_next  = step_reg + 3'h1;
			end
			fwpc_pkg::S_RACC: begin
				if (tmr_expired) begin
					state_next = fwpc_pkg::S_PLAN;
					bus_next   = dq_in;
					step_next  = step_reg + 3'h1;
					if (op_reg != fwpc_pkg::OP_READ)
						status_next = dq_in[7:0];
					// keep polling until the write state machine reports ready
					if ((op_reg == fwpc_pkg::OP_PROGRAM || op_reg == fwpc_pkg::OP_ERASE) &&
						!dq_in[`FWPC_SR_READY])
						step_next = step_reg;
				end
			end
			default: state_next = fwpc_pkg::S_PDOWN;
		endcase
		// power loss, or a user abort of a running operation, pulls the reset pin
		if (state_reg != fwpc_pkg::S_PDOWN &&
			(!supply_good || (abort && state_reg != fwpc_pkg::S_IDLE &&
			state_reg != fwpc_pkg::S_RECOVER))) begin
			state_next  = fwpc_pkg::S_PDOWN;
			abort_next  = abort && supply_good;
			status_next = '0;
			done_next   = 1'b0;
			tmr_load    = 1'b1;
			tmr_val     = TW'(RP_LOW_CYC);
		end
		if (state_reg == fwpc_pkg::S_PDOWN)
			abort_next = abort_reg;
		ready_next = (state_next == fwpc_pkg::S_IDLE && !done_next) ||
			(state_next == fwpc_pkg::S_PDOWN && sleep_next && !done_next);
	end

	// pin levels follow the state being entered
	always_comb begin
		pins_next                       = '0;
		pins_next.ce_n                  = 1'b1;
		pins_next.oe_n                  = 1'b1;
		pins_next.we_n                  = 1'b1;
		pins_next.dq_oe_n               = 1'b1;
		pins_next.powerdown_reset_pin_n = 1'b1;
		pins_next.wp_n                  = wp_unlock;
		pins_next.addr                  = addr_next;
		pins_next.dq_out                = bus_next;
		case (state_next)
			fwpc_pkg::S_PDOWN: begin
				pins_next.powerdown_reset_pin_n = 1'b0;
			end
			fwpc_pkg::S_WSET, fwpc_pkg::S_WHOLD: begin
				pins_next.ce_n    = 1'b0;
				pins_next.dq_oe_n = 1'b0;
			end
			fwpc_pkg::S_WPULSE: begin
				pins_next.ce_n    = 1'b0;
				pins_next.we_n    = 1'b0;
				pins_next.dq_oe_n = 1'b0;
			end
			fwpc_pkg::S_RACC: begin
				pins_next.ce_n = 1'b0;
				pins_next.oe_n = 1'b0;
			end
			default: pins_next.ce_n = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// reset pin low for as long as system reset is held
			state_reg  <= fwpc_pkg::S_PDOWN;
			op_reg     <= fwpc_pkg::OP_READ;
			addr_reg   <= '0;
			wdata_reg  <= '0;
			bus_reg    <= '0;
			status_reg <= '0;
			step_reg   <= 3'h0;
			array_reg  <= 1'b1;
			sleep_reg  <= 1'b0;
			abort_reg  <= 1'b0;
			ready_reg  <= 1'b0;
			done_reg   <= 1'b0;
			rsp_reg    <= '0;
			pins_reg   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, powerdown_reset_pin_n: 1'b0,
				wp_n: 1'b0, addr: '0, dq_out: '0, dq_oe_n: 1'b1};
		end else begin
			state_reg  <= state_next;
			op_reg     <= op_next;
			addr_reg   <= addr_next;
			wdata_reg  <= wdata_next;
			bus_reg    <= bus_next;
			status_reg <= status_next;
			step_reg   <= step_next;
			array_reg  <= array_next;
			sleep_reg  <= sleep_next;
			abort_reg  <= abort_next;
			ready_reg  <= ready_next;
			done_reg   <= done_next;
			rsp_reg    <= rsp_next;
			pins_reg   <= pins_next;
		end
	end

	assign req_ready = ready_reg;
	assign done      = done_reg;
	assign rsp       = rsp_reg;
	assign pins      = pins_reg;

endmodule

// ==== design/fwpc_params.svh ====
/*
 * Constants for the boot-block flash host controller: bus widths, command
 * codes, status bit positions and the bus timing figures in nanoseconds.
 * Assumes a 100 MHz controller clock; cycle counts are derived by the users.
 */
`ifndef FWPC_PARAMS_SVH
`define FWPC_PARAMS_SVH

`define FWPC_ADDR_W         22
`define FWPC_DATA_W         16

// controller clock period
`define FWPC_CLK_NS         10

// read access, write-strobe low width, reset low width, recovery after reset
`define FWPC_T_ACC_NS       70
`define FWPC_T_WE_LOW_NS    50
`define FWPC_T_RP_LOW_NS    100
`define FWPC_T_PD_RECOVER_NS 150

// command codes
`define FWPC_CMD_READ_ARRAY 8'hFF
`define FWPC_CMD_READ_STAT  8'h70
`define FWPC_CMD_CLR_STAT   8'h50
`define FWPC_CMD_PROGRAM    8'h40
`define FWPC_CMD_ERASE      8'h20
`define FWPC_CMD_CONFIRM    8'hD0

// status byte bit positions
`define FWPC_SR_READY       7
`define FWPC_SR_ERASE_ERR   5
`define FWPC_SR_PROG_ERR    4
`define FWPC_SR_SUPPLY      3
`define FWPC_SR_LOCK        1

`endif

// ==== design/fwpc_pkg.sv ====
/*
 * Types of the boot-block flash host controller: request and answer
 * carriers, the pin bundle and the controller states.
 * Assumes fwpc_params.svh is on the include path.
 */
`include "fwpc_params.svh"

package fwpc_pkg;

	typedef enum logic [2:0] {
		OP_READ,
		OP_READ_STATUS,
		OP_CLR_STATUS,
		OP_PROGRAM,
		OP_ERASE,
		OP_SLEEP,
		OP_WAKE
	} fwpc_op_t;

	typedef enum {
		ACT_WRITE,
		ACT_READ,
		ACT_FINISH
	} fwpc_act_t;

	typedef enum {
		S_PDOWN,
		S_RECOVER,
		S_IDLE,
		S_PLAN,
		S_WSET,
		S_WPULSE,
		S_WHOLD,
		S_RACC
	} fwpc_state_t;

	typedef struct packed {
		fwpc_op_t                 op;
		logic [`FWPC_ADDR_W-1:0] addr;
		logic [`FWPC_DATA_W-1:0] wdata;
	} fwpc_req_t;

	typedef struct packed {
		logic [`FWPC_DATA_W-1:0] rdata;
		logic [7:0]              status;
		logic                    lock_err;
		logic                    supply_err;
		logic                    fail;
		logic                    aborted;
	} fwpc_rsp_t;

	typedef struct packed {
		logic                    ce_n;
		logic                    oe_n;
		logic                    we_n;
		logic                    powerdown_reset_pin_n;
		logic                    wp_n;
		logic [`FWPC_ADDR_W-1:0] addr;
		logic [`FWPC_DATA_W-1:0] dq_out;
		logic                    dq_oe_n;
	} fwpc_pins_t;

endpackage

// ==== design/fwpc_timer.sv ====
/*
 * Down-counting wait timer for the flash host controller.
 * A load overrides the running count, so the loader may reload before expired is seen.
 */
`timescale 1ns/1ps

module fwpc_timer #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	// state
	output logic              expired
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		if (load)
			count_next = load_val;
		else if (count_reg != '0)
			count_next = count_reg - W'(1);
		else
			count_next = count_reg;
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	assign expired = (count_reg == '0);

endmodule

// ==== verif/fwpc_ctrl_asserts.sv ====
/*
 * Pin-level checks of the host duties of fwpc_ctrl.
 * Assumes it is bound into fwpc_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ps

module fwpc_ctrl_asserts #(
	parameter int RP_LOW_CYC = 10
) (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 reset_n,
	// system side
	input wire logic                 supply_good,
	input wire logic                 wp_unlock,
	input wire logic                 req_valid,
	input wire logic                 req_ready,
	input wire logic                 done,
	// flash pins
	input wire fwpc_pkg::fwpc_pins_t pins
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	we_select_a: assert property (!pins.we_n |-> !pins.ce_n)
		else $error("write strobe low without chip select");
	we_drive_a: assert property (!pins.we_n |-> !pins.dq_oe_n && pins.oe_n)
		else $error("write strobe low while not driving data");
	rst_follow_a: assert property (disable iff (1'b0) !reset_n |=> !pins.powerdown_reset_pin_n)
		else $error("flash reset pin not following system reset");
	supply_cut_a: assert property (!supply_good |=> !pins.powerdown_reset_pin_n)
		else $error("flash reset pin high with bad supply");
	rp_hold_a: assert property ($rose(pins.powerdown_reset_pin_n) |->
		!$past(pins.powerdown_reset_pin_n, RP_LOW_CYC))
		else $error("flash reset pin released too early");
	wp_level_a: assert property (wp_unlock [*3] |=> pins.wp_n)
		else $error("write protect pin not following unlock");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	take_busy_a: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready stayed high after a take");
endmodule

bind fwpc_ctrl fwpc_ctrl_asserts #(.RP_LOW_CYC(RP_LOW_CYC)) u_fwpc_ctrl_asserts (
	.clk(clk), .reset_n(reset_n), .supply_good(supply_good), .wp_unlock(wp_unlock),
	.req_valid(req_valid), .req_ready(req_ready), .done(done), .pins(pins));

// ==== verif/fwpc_flash_model.sv ====
/*
 * Behavioural boot-block flash seen from its pins, bottom-boot by default.
 * Assumes pins change only just after clk edges; dq is read back by the host.
 */
`timescale 1ns/1ps

module fwpc_flash_model #(
	parameter int BUSY_CYC  = 40,
	parameter int BLK_SHIFT = 12,
	parameter int LOCK_LO   = 0
) (
	// clock and supply
	input wire logic                 clk,
	input wire logic                 vpp_ok,
	// bus
	input wire fwpc_pkg::fwpc_pins_t pins,
	output logic [15:0]              dq
);
	logic [15:0] mem [logic [21:0]];
	logic [7:0]  sr          = 8'h00;
	logic        status_mode = 1'b0;
	logic        we_q        = 1'b1;
	logic        k_erase     = 1'b0;
	logic [1:0]  pend        = 2'h0;
	logic [21:0] t_addr;
	logic [15:0] t_data;
	int          busy        = 0;

	function automatic logic lockd(input logic [21:0] a);
		lockd = !pins.wp_n && ((a >> BLK_SHIFT) - LOCK_LO < 2);
	endfunction

	always @(posedge clk) begin
		we_q <= pins.we_n;
		if (!pins.powerdown_reset_pin_n) begin
			if (busy > 0)
				mem[t_addr] = 16'hXXXX;
			busy <= 0;
			sr <= 8'h00;
			status_mode <= 1'b0;
			pend <= 2'h0;
		end else begin
			if (busy > 0)
				busy <= busy - 1;
			if (busy == 1 && !vpp_ok) begin
				sr <= sr | 8'h08;
			end else if (busy == 1 && k_erase) begin
				foreach (mem[a]) begin
					if ((a >> BLK_SHIFT) == (t_addr >> BLK_SHIFT))
						mem[a] = 16'hFFFF;
				end
			end else if (busy == 1) begin
				mem[t_addr] = t_data;
			end
			if (pins.we_n && !we_q && !pins.ce_n) begin
				if (pend != 2'h0) begin
					pend <= 2'h0;
					if (lockd(pins.addr))
						sr <= sr | 8'h02;
					else if (!vpp_ok)
						sr <= sr | 8'h08;
					else if (pend == 2'h1 || pins.dq_out[7:0] == 8'hD0) begin
						busy <= BUSY_CYC;
						t_addr <= pins.addr;
						t_data <= pins.dq_out;
						k_erase <= (pend == 2'h2);
					end else
						sr <= sr | 8'hB0;
				end else begin
					case (pins.dq_out[7:0])
						8'hFF: status_mode <= 1'b0;
						8'h70: status_mode <= 1'b1;
						8'h50: sr <= 8'h00;
						8'h40: pend <= 2'h1;
						8'h20: pend <= 2'h2;
						default: ;
					endcase
					if (pins.dq_out[7:0] == 8'h40 || pins.dq_out[7:0] == 8'h20)
						status_mode <= 1'b1;
				end
			end
		end
	end

	// selected read drives data; otherwise the floating bus keeps moving
	always @(posedge clk) begin
		if (pins.powerdown_reset_pin_n && !pins.ce_n && !pins.oe_n)
			dq <= status_mode ? {8'h00, sr | {busy == 0, 7'h00}}
				: (mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF);
		else
			dq <= ~dq;
	end

	initial dq = 16'h0000;
endmodule

// ==== verif/fwpc_ctrl_test.sv ====
/*
 * Self-checking bench of fwpc_ctrl against the behavioural flash model.
 * Assumes short timing parameters; bottom-boot locking of blocks 0 and 1.
 */
`timescale 1ns/1ps

module fwpc_ctrl_test;
	logic                 clk, reset_n, supply_good, wp_unlock, abort, req_valid, vpp_ok;
	logic                 req_ready, done;
	logic [15:0]          dq_in;
	fwpc_pkg::fwpc_req_t  req;
	fwpc_pkg::fwpc_rsp_t  rsp;
	fwpc_pkg::fwpc_pins_t pins;
	int                   n_mismatch = 0;
	int                   checks_done = 0;

	fwpc_ctrl #(.ACC_CYC(2), .WE_CYC(2), .RP_LOW_CYC(3), .RECOVER_CYC(3)) u_fwpc_ctrl (
		.clk(clk), .reset_n(reset_n), .supply_good(supply_good), .wp_unlock(wp_unlock),
		.abort(abort), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.done(done), .rsp(rsp), .pins(pins), .dq_in(dq_in));
	fwpc_flash_model u_fwpc_flash_model (.clk(clk), .vpp_ok(vpp_ok), .pins(pins), .dq(dq_in));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic op(input fwpc_pkg::fwpc_op_t o, input logic [21:0] a, input logic [15:0] d);
		int i;
		i = 0;
		while (req_ready !== 1'b1 && i < 500) begin
			@(posedge clk);
			#1 i++;
		end
		req = '{op: o, addr: a, wdata: d};
		req_valid = 1'b1;
		@(posedge clk);
		#1 req_valid = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 2000) begin
			@(posedge clk);
			#1 i++;
		end
		chk(done, 1'b1);
	endtask

	task automatic t_unlocked();
		wp_unlock = 1'b1;
		op(fwpc_pkg::OP_PROGRAM, 22'h002010, 16'hA5C3);
		chk(rsp.fail, 1'b0);
		op(fwpc_pkg::OP_READ, 22'h002010, 16'h0000);
		chk(rsp.rdata, 16'hA5C3);
		op(fwpc_pkg::OP_PROGRAM, 22'h001004, 16'h3C5A);
		op(fwpc_pkg::OP_READ, 22'h001004, 16'h0000);
		chk(rsp.rdata, 16'h3C5A);
	endtask

	task automatic t_locked();
		wp_unlock = 1'b0;
		op(fwpc_pkg::OP_PROGRAM, 22'h000008, 16'h1234);
		chk({rsp.lock_err, rsp.fail}, 2'h3);
		op(fwpc_pkg::OP_READ_STATUS, 22'h000000, 16'h0000);
		chk(rsp.status, 8'h82);
		op(fwpc_pkg::OP_CLR_STATUS, 22'h000000, 16'h0000);
		op(fwpc_pkg::OP_READ_STATUS, 22'h000000, 16'h0000);
		chk(rsp.status, 8'h80);
		op(fwpc_pkg::OP_READ, 22'h000008, 16'h0000);
		chk(rsp.rdata, 16'hFFFF);
		op(fwpc_pkg::OP_ERASE, 22'h001000, 16'h0000);
		chk(rsp.lock_err, 1'b1);
		op(fwpc_pkg::OP_CLR_STATUS, 22'h000000, 16'h0000);
	endtask

	task automatic t_supply_low();
		vpp_ok = 1'b0;
		op(fwpc_pkg::OP_PROGRAM, 22'h003000, 16'h0F0F);
		chk({rsp.supply_err, rsp.fail}, 2'h3);
		op(fwpc_pkg::OP_READ_STATUS, 22'h000000, 16'h0000);
		chk(rsp.status, 8'h88);
		vpp_ok = 1'b1;
		op(fwpc_pkg::OP_CLR_STATUS, 22'h000000, 16'h0000);
		op(fwpc_pkg::OP_ERASE, 22'h002000, 16'h0000);
		op(fwpc_pkg::OP_READ, 22'h002010, 16'h0000);
		chk(rsp.rdata, 16'hFFFF);
	endtask

	task automatic t_abort();
		op(fwpc_pkg::OP_PROGRAM, 22'h004000, 16'h7777);
		fork
			op(fwpc_pkg::OP_PROGRAM, 22'h004002, 16'h5555);
			begin
				repeat (30) @(posedge clk);
				#1 abort = 1'b1;
				@(posedge clk);
				#1 abort = 1'b0;
			end
		join
		chk({rsp.aborted, rsp.fail}, 2'h3);
		op(fwpc_pkg::OP_READ_STATUS, 22'h000000, 16'h0000);
		chk(rsp.status, 8'h80);
		op(fwpc_pkg::OP_READ, 22'h004000, 16'h0000);
		chk(rsp.rdata, 16'h7777);
	endtask

	task automatic t_power();
		op(fwpc_pkg::OP_SLEEP, 22'h000000, 16'h0000);
		chk(pins.powerdown_reset_pin_n, 1'b0);
		repeat (5) @(posedge clk);
		#1 op(fwpc_pkg::OP_WAKE, 22'h000000, 16'h0000);
		op(fwpc_pkg::OP_PROGRAM, 22'h000100, 16'h4444);
		chk(rsp.lock_err, 1'b1);
		supply_good = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(pins.powerdown_reset_pin_n, 1'b0);
		supply_good = 1'b1;
		op(fwpc_pkg::OP_READ_STATUS, 22'h000000, 16'h0000);
		chk(rsp.status, 8'h80);
		op(fwpc_pkg::OP_READ, 22'h001004, 16'h0000);
		chk(rsp.rdata, 16'h3C5A);
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#300000;
		n_mismatch++;
		end_of_test();
	end

	initial begin
		reset_n = 1'b0;
		supply_good = 1'b1;
		wp_unlock = 1'b0;
		abort = 1'b0;
		req_valid = 1'b0;
		vpp_ok = 1'b1;
		req = '0;
		repeat (12) @(posedge clk);
		#1 reset_n = 1'b1;
		t_unlocked();
		t_locked();
		t_supply_low();
		t_abort();
		t_power();
		end_of_test();
	end
endmodule
